//--- verilog/crs_register_set.sv
// Programmer-visible register set of an 8-bit CPU core with an AHB-Lite register window.
// Assumes the decoder issues at most one interrupt-flop operation per cycle
// and that the AHB master performs single word transfers only.
`timescale 1ns/1ns
`include "crs_regs.svh"

module crs_register_set
   import crs_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // General pair from the datapath
   input wire logic gp_we_upper,
   input wire logic gp_we_lower,
   input wire logic [15:0] gp_wdata,
   input wire logic exchange,
   output logic [15:0] gp_pair,
   // Fetch, program counter and stack
   input wire logic fetch,
   input wire logic pc_inc,
   input wire logic pc_load,
   input wire logic [15:0] pc_value,
   input wire logic sp_push,
   input wire logic sp_pop,
   output logic [15:0] next_fetch_address,
   output logic [15:0] stack_top_pointer,
   output logic [15:0] refresh_addr,
   output logic [15:0] index_first,
   output logic [15:0] index_second,
   // Interrupt control
   input wire logic ei,
   input wire logic di,
   input wire logic nmi_accept,
   input wire logic return_from_nonmaskable,
   input wire logic im_set,
   input wire logic [1:0] im_value,
   input wire logic int_ack,
   input wire logic [7:0] periph_vector,
   output logic [1:0] int_enable_flops,
   output logic [1:0] int_mode_flops,
   output logic [15:0] service_addr,
   output logic vector_odd
);

   logic [7:0] upper_q [2];
   logic [7:0] lower_q [2];
   logic alt_sel_q;
   logic [7:0] int_page_q;
   logic [7:0] refresh_q;
   logic [15:0] refresh_addr_q;
   logic [15:0] index_first_q;
   logic [15:0] index_second_q;
   logic [15:0] stack_q;
   logic [15:0] pc_q;
   logic iff1_q;
   logic iff2_q;
   crs_int_mode_t mode_q;
   logic [15:0] service_q;
   logic vector_odd_q;
   logic dp_wr_q;
   logic [7:0] dp_addr_q;
   logic [31:0] hrdata_q;
   logic ap_valid;
   logic bus_wr;

   // Read decode only; the write-hit check uses is_wr instead
   function automatic logic [31:0] reg_read(input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         `CRS_OFF_GEN_PAIR: r = {16'h0000, upper_q[alt_sel_q], lower_q[alt_sel_q]};
         `CRS_OFF_INT_PAGE: r = {24'h00_0000, int_page_q};
         `CRS_OFF_REFRESH: r = {24'h00_0000, refresh_q};
         `CRS_OFF_INDEX_FIRST: r = {16'h0000, index_first_q};
         `CRS_OFF_INDEX_SECOND: r = {16'h0000, index_second_q};
         `CRS_OFF_STACK_TOP: r = {16'h0000, stack_q};
         `CRS_OFF_NEXT_FETCH: r = {16'h0000, pc_q};
         `CRS_OFF_INT_CTRL: r = {27'h000_0000, alt_sel_q, mode_q, iff2_q, iff1_q};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   function automatic logic is_wr(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // Zero-wait slave; every response is OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign ap_valid = hsel & htrans[1] & hready;
   assign bus_wr = dp_wr_q;

   // Address phase capture; read data is fetched early so it comes from a flop
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr_q <= 1'b0;
         dp_addr_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end
      else
      begin
         dp_wr_q <= ap_valid & hwrite;
         dp_addr_q <= haddr[7:0];
         if (ap_valid & ~hwrite)
            hrdata_q <= (haddr[31:8] == 24'h00_0000) ? reg_read(haddr[7:0]) : 32'h0000_0000;
      end
   end

   // Visible copy select; a swap only flips the pointer, so it is atomic
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         alt_sel_q <= 1'b0;
      else if (exchange | (bus_wr & is_wr(dp_addr_q, `CRS_OFF_COMMAND)
               & hwdata[`CRS_CMD_EXCHANGE_BIT]))
         alt_sel_q <= ~alt_sel_q;
   end

   // Two copies of the pair; only the visible one takes writes
   generate
      for (genvar b = 0; b < 2; b++)
      begin : g_bank
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               upper_q[b] <= `CRS_RST_BYTE;
               lower_q[b] <= `CRS_RST_BYTE;
            end
            else if (alt_sel_q == 1'(b))
            begin
               // Datapath writes win over a bus write in the same cycle
               if (gp_we_upper)
                  upper_q[b] <= gp_wdata[15:8];
               else if (bus_wr & is_wr(dp_addr_q, `CRS_OFF_GEN_PAIR))
                  upper_q[b] <= hwdata[15:8];
               if (gp_we_lower)
                  lower_q[b] <= gp_wdata[7:0];
               else if (bus_wr & is_wr(dp_addr_q, `CRS_OFF_GEN_PAIR))
                  lower_q[b] <= hwdata[7:0];
            end
         end
      end
   endgenerate
   assign gp_pair = {upper_q[alt_sel_q], lower_q[alt_sel_q]};

   // Page and index registers are software-loaded only
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         int_page_q <= `CRS_RST_BYTE;
         index_first_q <= `CRS_RST_WORD;
         index_second_q <= `CRS_RST_WORD;
      end
      else if (bus_wr)
      begin
         if (is_wr(dp_addr_q, `CRS_OFF_INT_PAGE))
            int_page_q <= hwdata[7:0];
         if (is_wr(dp_addr_q, `CRS_OFF_INDEX_FIRST))
            index_first_q <= hwdata[15:0];
         if (is_wr(dp_addr_q, `CRS_OFF_INDEX_SECOND))
            index_second_q <= hwdata[15:0];
      end
   end

   // Refresh counter; the fetch increment beats a software load
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         refresh_q <= `CRS_RST_BYTE;
         refresh_addr_q <= `CRS_RST_WORD;
      end
      else if (fetch)
      begin
         refresh_addr_q <= {int_page_q, refresh_q};
         refresh_q <= refresh_q + 8'h01;
      end
      else if (bus_wr & is_wr(dp_addr_q, `CRS_OFF_REFRESH))
         refresh_q <= hwdata[7:0];
   end

   // Stack pointer moves by one word per push or pop
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         stack_q <= `CRS_RST_STACK;
      else if (sp_push)
         stack_q <= stack_q - `CRS_STACK_STEP;
      else if (sp_pop)
         stack_q <= stack_q + `CRS_STACK_STEP;
      else if (bus_wr & is_wr(dp_addr_q, `CRS_OFF_STACK_TOP))
         stack_q <= hwdata[15:0];
   end

   // Program counter; a pc_load of pc_value beats an increment, which beats a bus write
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pc_q <= `CRS_RST_NEXT_FETCH;
      else if (pc_load)
         pc_q <= pc_value;
      else if (pc_inc)
         pc_q <= pc_q + `CRS_FETCH_STEP;
      else if (bus_wr & is_wr(dp_addr_q, `CRS_OFF_NEXT_FETCH))
         pc_q <= hwdata[15:0];
   end

   // Enable flops; an NMI accept outranks every other source
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         iff1_q <= 1'b0;
         iff2_q <= 1'b0;
      end
      else if (nmi_accept)
      begin
         iff2_q <= iff1_q;
         iff1_q <= 1'b0;
      end
      else if (ei)
      begin
         iff1_q <= 1'b1;
         iff2_q <= 1'b1;
      end
      else if (di)
      begin
         iff1_q <= 1'b0;
         iff2_q <= 1'b0;
      end
      else if (return_from_nonmaskable)
         iff1_q <= iff2_q;
      else if (bus_wr & is_wr(dp_addr_q, `CRS_OFF_INT_CTRL))
      begin
         iff1_q <= hwdata[`CRS_CTRL_IFF1_BIT];
         iff2_q <= hwdata[`CRS_CTRL_IFF2_BIT];
      end
   end

   // Mode flops; the unused code 3 is refused and the mode kept
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mode_q <= CRS_MODE_0;
      else if (im_set & (im_value != 2'b11))
         mode_q <= crs_int_mode_t'(im_value);
      else if (bus_wr & is_wr(dp_addr_q, `CRS_OFF_INT_CTRL)
               & (hwdata[`CRS_CTRL_MODE_LSB+1 -: 2] != 2'b11))
         mode_q <= crs_int_mode_t'(hwdata[`CRS_CTRL_MODE_LSB+1 -: 2]);
   end
   assign int_enable_flops = {iff2_q, iff1_q};
   assign int_mode_flops = mode_q;

   // Service address; bit 0 of the vector is forced low so a bad peripheral
   // cannot send the table read to an odd word
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         service_q <= `CRS_RST_WORD;
         vector_odd_q <= 1'b0;
      end
      else if (nmi_accept)
         service_q <= `CRS_NMI_SERVICE;
      else if (int_ack)
      begin
         unique case (mode_q)
            CRS_MODE_2:
            begin
               service_q <= {int_page_q, periph_vector[7:1], 1'b0};
               vector_odd_q <= periph_vector[0];
            end
            CRS_MODE_1: service_q <= `CRS_MODE1_SERVICE;
            CRS_MODE_0: service_q <= service_q;
            default: service_q <= service_q;
         endcase
      end
   end

   assign next_fetch_address = pc_q;
   assign stack_top_pointer = stack_q;
   assign refresh_addr = refresh_addr_q;
   assign index_first = index_first_q;
   assign index_second = index_second_q;
   assign service_addr = service_q;
   assign vector_odd = vector_odd_q;

   // Checks
   property p_pair_bytes;
      @(posedge hclk) disable iff (!hresetn)
      (gp_we_upper & ~gp_we_lower & ~exchange) |=> gp_pair == {$past(gp_wdata[15:8]),
         $past(gp_pair[7:0])};
   endproperty
   a_pair_bytes: assert property (p_pair_bytes) else $error("upper write bad");

   property p_bus_pair;
      @(posedge hclk) disable iff (!hresetn)
      (bus_wr & dp_addr_q == `CRS_OFF_GEN_PAIR & ~gp_we_upper & ~gp_we_lower & ~exchange)
      |=> gp_pair == $past(hwdata[15:0]);
   endproperty
   a_bus_pair: assert property (p_bus_pair) else $error("pair byte order bad");

   property p_refresh;
      @(posedge hclk) disable iff (!hresetn)
      fetch |=> (refresh_q == $past(refresh_q) + 8'h01) && (refresh_addr[7:0] == $past(refresh_q));
   endproperty
   a_refresh: assert property (p_refresh) else $error("refresh step bad");

   property p_push;
      @(posedge hclk) disable iff (!hresetn)
      sp_push |=> stack_top_pointer == $past(stack_top_pointer) - `CRS_STACK_STEP;
   endproperty
   a_push: assert property (p_push) else $error("push step bad");

   property p_pc_inc;
      @(posedge hclk) disable iff (!hresetn)
      (pc_inc & ~pc_load) |=> next_fetch_address == $past(next_fetch_address) + 16'h0001;
   endproperty
   a_pc_inc: assert property (p_pc_inc) else $error("pc step bad");

   property p_ei;
      @(posedge hclk) disable iff (!hresetn)
      (ei & ~nmi_accept) |=> int_enable_flops == 2'b11;
   endproperty
   a_ei: assert property (p_ei) else $error("enable not set");

   property p_nmi;
      @(posedge hclk) disable iff (!hresetn)
      nmi_accept |=> (int_enable_flops == {$past(iff1_q), 1'b0}) &&
         (service_addr == `CRS_NMI_SERVICE);
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi copy bad");

   property p_mode;
      @(posedge hclk) disable iff (!hresetn)
      (im_set & im_value != 2'b11) |=> int_mode_flops == $past(im_value);
   endproperty
   a_mode: assert property (p_mode) else $error("mode not taken");

   property p_vector;
      @(posedge hclk) disable iff (!hresetn)
      (int_ack & ~nmi_accept & mode_q == CRS_MODE_2) |=>
         service_addr == {$past(int_page_q), $past(periph_vector[7:1]), 1'b0};
   endproperty
   a_vector: assert property (p_vector) else $error("vector address bad");

   property p_swap;
      @(posedge hclk) disable iff (!hresetn)
      (exchange & ~bus_wr) |=> gp_pair == {$past(upper_q[~alt_sel_q]), $past(lower_q[~alt_sel_q])};
   endproperty
   a_swap: assert property (p_swap) else $error("exchange bad");

   c_swap_twice: cover property (@(posedge hclk) disable iff (!hresetn) exchange ##1 exchange);
   c_nmi_return: cover property (@(posedge hclk) disable iff (!hresetn)
      nmi_accept ##[1:20] return_from_nonmaskable);
   c_vectored: cover property (@(posedge hclk) disable iff (!hresetn)
      int_ack & mode_q == CRS_MODE_2);

endmodule

//--- shared/crs_regs.svh
// Offsets, field positions, reset values and fixed counts of the CPU register set.
// Assumes a 32-bit AHB-Lite register window with one register per aligned word.
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH

// Register byte offsets
`define CRS_OFF_GEN_PAIR 8'h00
`define CRS_OFF_INT_PAGE 8'h04
`define CRS_OFF_REFRESH 8'h08
`define CRS_OFF_INDEX_FIRST 8'h0c
`define CRS_OFF_INDEX_SECOND 8'h10
`define CRS_OFF_STACK_TOP 8'h14
`define CRS_OFF_NEXT_FETCH 8'h18
`define CRS_OFF_INT_CTRL 8'h1c
`define CRS_OFF_COMMAND 8'h20

// Interrupt control word fields
`define CRS_CTRL_IFF1_BIT 0
`define CRS_CTRL_IFF2_BIT 1
`define CRS_CTRL_MODE_LSB 2
`define CRS_CTRL_ALT_BIT 4
// Command word fields
`define CRS_CMD_EXCHANGE_BIT 0

// Reset values
`define CRS_RST_BYTE 8'h00
`define CRS_RST_WORD 16'h0000
`define CRS_RST_STACK 16'hffff
`define CRS_RST_NEXT_FETCH 16'h0000

// Fixed service addresses and step sizes
`define CRS_NMI_SERVICE 16'h0066
`define CRS_MODE1_SERVICE 16'h0038
`define CRS_STACK_STEP 16'h0002
`define CRS_FETCH_STEP 16'h0001

`endif

//--- shared/crs_pkg.sv
// Types shared by the CPU register set and its surroundings.
// Assumes crs_regs.svh holds all numeric constants.
package crs_pkg;
   // Maskable interrupt response modes held in the mode flops
   typedef enum logic [1:0] {
      CRS_MODE_0 = 2'b00,
      CRS_MODE_1 = 2'b01,
      CRS_MODE_2 = 2'b10
   } crs_int_mode_t;

   typedef logic [15:0] crs_word_t;
   typedef logic [7:0] crs_byte_t;
endpackage

//--- verification/tb_top.sv
// Self-checking bench for the CPU register set: bus window and datapath strobes.
// Assumes a single AHB-Lite master (this bench) and zero-wait slave answers.
`timescale 1ns/1ns
`include "crs_regs.svh"
module tb_top
   import crs_pkg::*;
;
   // Clock, reset and bus
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, vector_odd;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0] htrans, im_value, int_enable_flops, int_mode_flops;
   logic [2:0] hsize;
   // Datapath strobes and results
   logic gp_we_upper, gp_we_lower, exchange, fetch, pc_inc, pc_load, sp_push, sp_pop;
   logic ei, di, nmi_accept, return_from_nonmaskable, im_set, int_ack;
   logic [15:0] gp_wdata, gp_pair, pc_value, next_fetch_address, stack_top_pointer;
   logic [15:0] refresh_addr, index_first, index_second, service_addr;
   logic [7:0] periph_vector;
   int bad_count, cmp_count;

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;

   crs_register_set i_crs_register_set (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .gp_we_upper(gp_we_upper), .gp_we_lower(gp_we_lower), .gp_wdata(gp_wdata),
      .exchange(exchange), .gp_pair(gp_pair), .fetch(fetch), .pc_inc(pc_inc),
      .pc_load(pc_load), .pc_value(pc_value), .sp_push(sp_push), .sp_pop(sp_pop),
      .next_fetch_address(next_fetch_address), .stack_top_pointer(stack_top_pointer),
      .refresh_addr(refresh_addr), .index_first(index_first), .index_second(index_second),
      .ei(ei), .di(di), .nmi_accept(nmi_accept),
      .return_from_nonmaskable(return_from_nonmaskable), .im_set(im_set),
      .im_value(im_value), .int_ack(int_ack), .periph_vector(periph_vector),
      .int_enable_flops(int_enable_flops), .int_mode_flops(int_mode_flops),
      .service_addr(service_addr), .vector_odd(vector_odd)
   );

   // 100 ns period
   always #50 hclk = ~hclk;

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Bounded wait for ready; gives up after 50 extra cycles so a slave that never answers cannot hang the bench
   task wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge hclk);
      end
   endtask

   task bus_xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                 output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy;
      rd = hrdata;
   endtask

   // The write lands at the closing edge, so let it settle before anyone looks
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus_xfer(1'b1, a, d, rdv);
      #1;
   endtask

   task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      bus_xfer(1'b0, a, 32'h00000000, rdv);
      chk(name, exp, rdv);
   endtask

   // Strobes are one-cycle pulses: drop them at the taking edge, then let outputs settle
   task settle;
      @(posedge hclk);
      {gp_we_upper, gp_we_lower, exchange, fetch, pc_inc, pc_load} <= 6'h00;
      {sp_push, sp_pop, ei, di, nmi_accept, return_from_nonmaskable, im_set, int_ack} <= 8'h00;
      #1;
   endtask

   task t_reset_values;
      chk("hresp", 32'h0, {31'h0, hresp});
      rd_chk("pair", `CRS_OFF_GEN_PAIR, 32'h0);
      rd_chk("stack", `CRS_OFF_STACK_TOP, {16'h0, `CRS_RST_STACK});
      rd_chk("ctrl", `CRS_OFF_INT_CTRL, 32'h0);
      rd_chk("unmapped", 8'h24, 32'h0);
   endtask

   task t_pair_exchange;
      wr(`CRS_OFF_GEN_PAIR, 32'h00001234);
      chk("gp_pair", 32'h1234, {16'h0, gp_pair});
      @(posedge hclk);
      exchange <= 1'b1;
      settle;
      chk("alt pair", 32'h0, {16'h0, gp_pair});
      @(posedge hclk);
      gp_we_upper <= 1'b1;
      gp_wdata <= 16'hab77;
      settle;
      chk("upper only", 32'hab00, {16'h0, gp_pair});
      rd_chk("alt flag", `CRS_OFF_INT_CTRL, 32'h10);
      wr(`CRS_OFF_COMMAND, 32'h1);
      rd_chk("pair back", `CRS_OFF_GEN_PAIR, 32'h1234);
   endtask

   task t_refresh_index;
      wr(`CRS_OFF_INT_PAGE, 32'ha5);
      wr(`CRS_OFF_REFRESH, 32'hff);
      @(posedge hclk);
      fetch <= 1'b1;
      settle;
      chk("refresh_addr", 32'ha5ff, {16'h0, refresh_addr});
      rd_chk("refresh wrap", `CRS_OFF_REFRESH, 32'h0);
      wr(`CRS_OFF_INDEX_FIRST, 32'hcafe);
      wr(`CRS_OFF_INDEX_SECOND, 32'hf00d);
      chk("index_first", 32'hcafe, {16'h0, index_first});
      chk("index_second", 32'hf00d, {16'h0, index_second});
   endtask

   task t_stack_pc;
      @(posedge hclk);
      sp_push <= 1'b1;
      sp_pop <= 1'b1;
      pc_load <= 1'b1;
      pc_inc <= 1'b1;
      pc_value <= 16'h4321;
      settle;
      chk("push wins", 32'hfffd, {16'h0, stack_top_pointer});
      chk("load wins", 32'h4321, {16'h0, next_fetch_address});
      @(posedge hclk);
      sp_pop <= 1'b1;
      pc_inc <= 1'b1;
      settle;
      chk("pop", 32'hffff, {16'h0, stack_top_pointer});
      rd_chk("pc", `CRS_OFF_NEXT_FETCH, 32'h4322);
   endtask

   // Modes 0..2 then the refused code 3; an acknowledge in the same cycle as a
   // mode change still uses the old mode, so mode 1 shows on the next pass
   task t_modes;
      for (int m = 0; m < 4; m++)
      begin
         @(posedge hclk);
         im_set <= 1'b1;
         im_value <= m[1:0];
         int_ack <= 1'b1;
         periph_vector <= 8'h41;
         settle;
         chk("mode", (m == 3) ? 32'h2 : m, {30'h0, int_mode_flops});
         if (m == 2)
            chk("mode1 addr", 32'h0038, {16'h0, service_addr});
      end
      @(posedge hclk);
      int_ack <= 1'b1;
      settle;
      chk("vector addr", 32'ha540, {16'h0, service_addr});
      chk("vector_odd", 32'h1, {31'h0, vector_odd});
   endtask

   task t_enable_flops;
      @(posedge hclk);
      ei <= 1'b1;
      settle;
      chk("ei", 32'h3, {30'h0, int_enable_flops});
      @(posedge hclk);
      nmi_accept <= 1'b1;
      settle;
      chk("nmi", 32'h2, {30'h0, int_enable_flops});
      chk("nmi addr", {16'h0, `CRS_NMI_SERVICE}, {16'h0, service_addr});
      @(posedge hclk);
      return_from_nonmaskable <= 1'b1;
      settle;
      chk("return", 32'h3, {30'h0, int_enable_flops});
      @(posedge hclk);
      di <= 1'b1;
      settle;
      chk("di", 32'h0, {30'h0, int_enable_flops});
   endtask

   task give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      {hclk, hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
      {gp_we_upper, gp_we_lower, exchange, fetch, pc_inc, pc_load, sp_push, sp_pop} = '0;
      {ei, di, nmi_accept, return_from_nonmaskable, im_set, int_ack, im_value} = '0;
      {gp_wdata, pc_value, periph_vector} = '0;
      hsize = 3'b010;
      bad_count = 0;
      cmp_count = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset_values;
      t_pair_exchange;
      t_refresh_index;
      t_stack_pc;
      t_modes;
      t_enable_flops;
      give_verdict;
   end

   // Watchdog: the tests need fewer than a hundred cycles
   initial
   begin
      repeat (5000) @(posedge hclk);
      bad_count++;
      give_verdict;
   end
endmodule
